// ---- shared/chan_cfg_pkg.sv ----
package chan_cfg_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 7;
  localparam int REG_W = 8;
  localparam int CNT_W = 10;
  localparam int HDR_W = 8;
  localparam int DATA_W = 24;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_STANDBY = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_PROF_A = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_PROF_B = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_PROF_SEL = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_POWER = 7'h04;

  // Reset values
  localparam logic [3:0] STANDBY_RST = 4'h0;
  localparam logic [3:0] PROF_RST = 4'hd;
  localparam logic [5:0] PROF_SEL_RST = 6'h00;
  localparam logic SLEEP_RST = 1'b0;

  // Field positions
  localparam int FILT_BIT = 3;
  localparam int DEC_MSB = 2;
  localparam int SEL_CH0 = 0;
  localparam int SEL_CH1 = 1;
  localparam int SEL_COPY_CH2 = 2;
  localparam int SEL_COPY_CH3 = 3;
  localparam int SEL_CH2 = 4;
  localparam int SEL_CH3 = 5;
  localparam int SLEEP_BIT = 7;
  localparam int REPEAT_BIT = 6;
  localparam int VCM_CH = 0;
  localparam int XTAL_CH = 2;

  // Decimation codes: 0 gives x32, codes from 5 up all give x1024
  localparam logic [2:0] DEC_CODE_MAX = 3'h5;
  localparam logic [CNT_W:0] MIN_RATIO = 11'h020;
  localparam logic [CNT_W:0] ONE_TICK = 11'h001;

  typedef struct packed {
    logic sinc5;
    logic [2:0] dec;
  } profile_s;

  typedef struct packed {
    logic [HDR_W-1:0] hdr;
    logic [DATA_W-1:0] data;
  } slot_s;

  typedef struct packed {
    logic standby;
    logic prof_b;
    logic sinc5;
    logic [2:0] dec_code;
  } chan_cfg_s;

  typedef struct packed {
    logic [NUM_CH-1:0] standby;
    profile_s prof_a;
    profile_s prof_b;
    logic [5:0] prof_sel;
    logic sleep;
    logic [CNT_W-1:0] tick_cnt;
    logic drdy;
    slot_s [NUM_CH-1:0] slot;
    logic [REG_W-1:0] rdata;
  } state_s;

endpackage : chan_cfg_pkg

// ---- rtl/channel_standby_mode_config.sv ----
module channel_standby_mode_config
  import chan_cfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  output logic [REG_W-1:0] reg_rdata_o,
  input wire logic mod_tick_i,
  input wire slot_s [NUM_CH-1:0] raw_slot_i,
  output slot_s [NUM_CH-1:0] slot_o,
  output logic drdy_o,
  output chan_cfg_s [NUM_CH-1:0] chan_cfg_o,
  output logic vcm_en_o,
  output logic xtal_en_o,
  output logic adc_en_o
);

  ////////////////////////////////////////////////////////////////////
  state_s st_r;
  state_s st_nxt;
  logic [CNT_W-1:0] mask [NUM_CH];
  logic [NUM_CH-1:0] fresh;
  logic [2:0] fast_code;
  logic [CNT_W-1:0] fast_mask;
  logic frame_end;
  logic wr_stb;

  // Ratio minus one for a decimation code, codes past the top clamp
  function automatic logic [CNT_W-1:0] ratio_mask(input logic [2:0] code);
    logic [2:0] c;
    logic [CNT_W:0] r;
    c = (code > DEC_CODE_MAX) ? DEC_CODE_MAX : code;
    r = (MIN_RATIO << c) - ONE_TICK;
    return r[CNT_W-1:0];
  endfunction : ratio_mask

  ////////////////////////////////////////////////////////////////////
  // Per-channel profile decode and frame freshness
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_chan
    localparam int SEL_POS = (i == 0) ? SEL_CH0 : (i == 1) ? SEL_CH1 :
                             (i == 2) ? SEL_CH2 : SEL_CH3;
    profile_s prof;
    assign prof = st_r.prof_sel[SEL_POS] ? st_r.prof_b : st_r.prof_a;
    assign chan_cfg_o[i].standby = st_r.standby[i];
    assign chan_cfg_o[i].prof_b = st_r.prof_sel[SEL_POS];
    assign chan_cfg_o[i].sinc5 = prof.sinc5;
    assign chan_cfg_o[i].dec_code = (prof.dec > DEC_CODE_MAX) ? DEC_CODE_MAX : prof.dec;
    assign mask[i] = ratio_mask(prof.dec);
    assign fresh[i] = ((st_r.tick_cnt & mask[i]) == mask[i]);
  end : g_chan

  ////////////////////////////////////////////////////////////////////
  // Fastest ratio over all channels sets the frame rate
  always_comb
  begin
    fast_code = chan_cfg_o[0].dec_code;
    for (int k = 1; k < NUM_CH; k++)
    begin
      if (chan_cfg_o[k].dec_code < fast_code)
      begin
        fast_code = chan_cfg_o[k].dec_code;
      end
    end
  end

  assign fast_mask = ratio_mask(fast_code);
  assign frame_end = mod_tick_i && !st_r.sleep &&
                     ((st_r.tick_cnt & fast_mask) == fast_mask);
  assign wr_stb = ce_i && reg_wr_i;

  ////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, counter and output slots
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i)
    begin
      // Register writes; only defined bits are stored
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          ADDR_STANDBY: st_nxt.standby = reg_wdata_i[NUM_CH-1:0];
          ADDR_PROF_A: st_nxt.prof_a = reg_wdata_i[FILT_BIT:0];
          ADDR_PROF_B: st_nxt.prof_b = reg_wdata_i[FILT_BIT:0];
          ADDR_PROF_SEL: st_nxt.prof_sel = reg_wdata_i[SEL_CH3:0];
          ADDR_POWER: st_nxt.sleep = reg_wdata_i[SLEEP_BIT];
          default: st_nxt.prof_sel = st_r.prof_sel;
        endcase
      end
      // Read port stays live in sleep; reserved bits read zero
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          ADDR_STANDBY: st_nxt.rdata = {4'h0, st_r.standby};
          ADDR_PROF_A: st_nxt.rdata = {4'h0, st_r.prof_a};
          ADDR_PROF_B: st_nxt.rdata = {4'h0, st_r.prof_b};
          ADDR_PROF_SEL: st_nxt.rdata = {2'h0, st_r.prof_sel};
          ADDR_POWER: st_nxt.rdata = {st_r.sleep, 7'h00};
          default: st_nxt.rdata = 8'h00;
        endcase
      end
      // Modulator tick counter, frozen in sleep
      if (mod_tick_i && !st_r.sleep)
      begin
        st_nxt.tick_cnt = st_r.tick_cnt + 10'h001;
      end
      // Frame assembly at the fastest rate
      st_nxt.drdy = frame_end;
      if (frame_end)
      begin
        for (int k = 0; k < NUM_CH; k++)
        begin
          if (st_r.standby[k])
          begin
            st_nxt.slot[k] = '0;
          end
          else if (fresh[k])
          begin
            st_nxt.slot[k] = raw_slot_i[k];
          end
          else
          begin
            st_nxt.slot[k].hdr = raw_slot_i[k].hdr;
            st_nxt.slot[k].hdr[REPEAT_BIT] = 1'b1;
            st_nxt.slot[k].data = '0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.standby <= STANDBY_RST;
      st_r.prof_a <= PROF_RST;
      st_r.prof_b <= PROF_RST;
      st_r.prof_sel <= PROF_SEL_RST;
      st_r.sleep <= SLEEP_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = st_r.rdata;
  assign slot_o = st_r.slot;
  assign drdy_o = st_r.drdy;
  assign vcm_en_o = !st_r.standby[VCM_CH];
  assign xtal_en_o = !st_r.standby[XTAL_CH];
  assign adc_en_o = !st_r.sleep;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Taken register accesses and taken frame edges
  sequence s_wr(logic [ADDR_W-1:0] a);
    wr_stb && reg_addr_i == a;
  endsequence

  sequence s_frame;
    ce_i && frame_end;
  endsequence

  sequence s_rd(logic [ADDR_W-1:0] a);
    ce_i && reg_rd_i && reg_addr_i == a;
  endsequence

  // Per-channel frame content, decode and slot holding
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_chk
    localparam int CHK_SEL = (i == 0) ? SEL_CH0 : (i == 1) ? SEL_CH1 :
                             (i == 2) ? SEL_CH2 : SEL_CH3;
    a_standby_slot_zero: assert property (
      s_frame ##0 st_r.standby[i] |=> slot_o[i] == '0 && drdy_o)
      else $error("standby slot not zero");
    a_repeat_mark_set: assert property (
      s_frame ##0 (!st_r.standby[i] && !fresh[i]) |=>
        slot_o[i].hdr[REPEAT_BIT] && slot_o[i].data == '0)
      else $error("repeat frame not marked");
    a_fresh_data_pass: assert property (
      s_frame ##0 (!st_r.standby[i] && fresh[i]) |=> slot_o[i] == $past(raw_slot_i[i]))
      else $error("fresh result not passed");
    a_dec_code_clamp: assert property (
      chan_cfg_o[i].dec_code <= DEC_CODE_MAX &&
        (chan_cfg_o[i].dec_code != DEC_CODE_MAX || mask[i] == '1))
      else $error("decimation code beyond range");

    // Register decode per channel, frame rate cover and slot holding between frames
    a_standby_follows_wr: assert property (
      s_wr(ADDR_STANDBY) |=> chan_cfg_o[i].standby == $past(reg_wdata_i[i]))
      else $error("standby bit not taken");
    a_map_follows_sel: assert property (
      s_wr(ADDR_PROF_SEL) |=> chan_cfg_o[i].prof_b == $past(reg_wdata_i[CHK_SEL]))
      else $error("profile map wrong");
    a_fast_covers_chan: assert property (
      (mask[i] & fast_mask) == fast_mask)
      else $error("frame rate slower than a channel");
    a_slot_hold: assert property (
      !(ce_i && frame_end) |=> $stable(slot_o[i]))
      else $error("slot changed between frames");
  end : g_chk

  // Side effects of standby on the analog enables
  a_vcm_off_ch0: assert property (
    s_wr(ADDR_STANDBY) ##0 reg_wdata_i[VCM_CH] |=> !vcm_en_o ##0 chan_cfg_o[VCM_CH].standby)
    else $error("common-mode output not disabled");
  a_xtal_off_ch2: assert property (
    s_wr(ADDR_STANDBY) |=> xtal_en_o != $past(reg_wdata_i[XTAL_CH]))
    else $error("crystal enable wrong");
  // Profile registers, channel mapping, data-ready rate, sleep and reserved bits
  a_profile_independent: assert property (
    s_wr(ADDR_PROF_B) |=> $stable(st_r.prof_a))
    else $error("profile A disturbed");
  a_filter_select: assert property (
    s_wr(ADDR_PROF_A) ##0 !st_r.prof_sel[SEL_CH1] |=>
      chan_cfg_o[1].sinc5 == $past(reg_wdata_i[FILT_BIT]))
    else $error("filter select wrong");
  a_sel_map_ch2: assert property (
    s_wr(ADDR_PROF_SEL) |=> chan_cfg_o[2].prof_b == $past(reg_wdata_i[SEL_CH2]))
    else $error("channel 2 profile map wrong");
  a_drdy_fastest: assert property (
    drdy_o && $past(ce_i) |->
      $past(mod_tick_i && !st_r.sleep && ((st_r.tick_cnt & fast_mask) == fast_mask)))
    else $error("data-ready off frame");
  a_sleep_wake: assert property (
    s_wr(ADDR_POWER) ##0 !reg_wdata_i[SLEEP_BIT] |=> adc_en_o ##1 adc_en_o || $past(wr_stb))
    else $error("sleep not cleared");
  a_sleep_no_drdy: assert property (
    st_r.sleep && ce_i |=> !drdy_o)
    else $error("data-ready while asleep");
  a_reserved_zero: assert property (
    ce_i && reg_rd_i && reg_addr_i == ADDR_STANDBY |=> reg_rdata_o[7:4] == 4'h0)
    else $error("reserved bits not zero");

  // Releasing channel 0 brings the common-mode output back
  a_vcm_on_ch0: assert property (
    s_wr(ADDR_STANDBY) ##0 !reg_wdata_i[VCM_CH] |=> vcm_en_o)
    else $error("common-mode output not restored");

  // Data-ready follows a taken frame edge and nothing else
  a_drdy_on_frame: assert property (
    s_frame |=> drdy_o)
    else $error("data-ready missing");
  a_drdy_off_idle: assert property (
    ce_i && !frame_end |=> !drdy_o)
    else $error("data-ready without frame");

  // Sleep stops the modulator counter but leaves the port alive
  a_sleep_enter: assert property (
    s_wr(ADDR_POWER) ##0 reg_wdata_i[SLEEP_BIT] |=> !adc_en_o)
    else $error("sleep not entered");
  a_tick_frozen: assert property (
    st_r.sleep |=> $stable(st_r.tick_cnt))
    else $error("counter ran in sleep");
  a_sleep_rd_live: assert property (
    s_rd(ADDR_POWER) ##0 st_r.sleep |=> reg_rdata_o[SLEEP_BIT])
    else $error("read port dead in sleep");

  // Unmapped addresses and reserved bits: writes dropped, reads give zero
  a_unmapped_wr: assert property (
    wr_stb && reg_addr_i > ADDR_POWER |=> $stable(st_r.standby) && $stable(st_r.prof_a) &&
      $stable(st_r.prof_b) && $stable(st_r.prof_sel) && $stable(st_r.sleep))
    else $error("unmapped write took effect");
  a_unmapped_rd: assert property (
    ce_i && reg_rd_i && reg_addr_i > ADDR_POWER |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_prof_rd_pad: assert property (
    s_rd(ADDR_PROF_B) |=> reg_rdata_o[REG_W-1:FILT_BIT+1] == '0)
    else $error("profile reserved bits not zero");
  a_sel_rd_pad: assert property (
    s_rd(ADDR_PROF_SEL) |=> reg_rdata_o[REG_W-1:SEL_CH3+1] == '0)
    else $error("select reserved bits not zero");

endmodule : channel_standby_mode_config

// ---- verification/reg_host.sv ----
// Host side of the register port: one strobe per access, bus scrambled when idle
module reg_host
  import chan_cfg_pkg::*;
(
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [REG_W-1:0] wdata_o,
  input wire logic [REG_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end

  // Write; companion select bits always copy their channel bits
  // Standby of channels 0 and 2 is allowed: no external common-mode or crystal use
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = (a == ADDR_PROF_SEL) ? {d[7:4], d[5:4], d[1:0]} : d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask : wr

  // Read; data is taken 1 ns after the read edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
endmodule : reg_host

// ---- verification/tb.sv ----
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb
  import chan_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic mod_tick_i = 1'b0;
  logic wr, rd, drdy, common_mode_voltage_out, xtal, adc;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0] wdata, rdata, d;
  slot_s [NUM_CH-1:0] raw, slot, cap;
  chan_cfg_s [NUM_CH-1:0] cfg;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_frames = 0;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h0d, 8'h0d, 8'h00, 8'h00};

  channel_standby_mode_config i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .mod_tick_i(mod_tick_i), .raw_slot_i(raw), .slot_o(slot),
    .drdy_o(drdy), .chan_cfg_o(cfg), .vcm_en_o(common_mode_voltage_out), .xtal_en_o(xtal), .adc_en_o(adc));
  reg_host i_host (.clk_i(sys_clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));

  // Clock, fixed raw results (header bit 6 clear) and watchdog
  initial
  begin
    for (int c = 0; c < NUM_CH; c++) raw[c] = 32'h0512_3450 + c;
    fork
      forever #5 sys_clk_i = ~sys_clk_i;
      begin
        repeat (20000) @(posedge sys_clk_i);
        n_mismatch++;
        finish_test();
      end
    join_none
  end

  // Frame monitor: counts data-ready pulses and captures the slots
  always @(posedge sys_clk_i)
  begin
    if (drdy === 1'b1)
    begin
      n_frames++;
      cap = slot;
    end
  end

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1 mod_tick_i = 1'b1;
      @(posedge sys_clk_i);
      #1 mod_tick_i = 1'b0;
    end
    repeat (3) @(posedge sys_clk_i);
  endtask : ticks

  task automatic t_reset();
    for (int a = 0; a < 5; a++)
    begin
      i_host.rd(a[ADDR_W-1:0], d);
      `CHK(d, rst_tab[a])
    end
    i_host.rd(7'h7f, d);
    `CHK(d, 8'h00)
    i_host.wr(7'h7f, 8'hff);
    i_host.rd(ADDR_POWER, d);
    `CHK({adc, common_mode_voltage_out, d}, 10'h300)
  endtask : t_reset

  task automatic t_standby();
    i_host.wr(ADDR_STANDBY, 8'hf5);
    i_host.rd(ADDR_STANDBY, d);
    `CHK(d, 8'h05)
    `CHK({common_mode_voltage_out, xtal, cfg[1].standby, cfg[2].standby}, 4'b0001)
    i_host.wr(ADDR_STANDBY, 8'h0a);
    `CHK({common_mode_voltage_out, xtal, cfg[3].standby, cfg[0].standby}, 4'b1110)
    i_host.wr(ADDR_PROF_B, 8'h0f);
    i_host.wr(ADDR_PROF_SEL, 8'h10);
    i_host.rd(ADDR_PROF_SEL, d);
    `CHK(d, 8'h14)
    `CHK({cfg[2].prof_b, cfg[2].sinc5, cfg[2].dec_code}, 5'b11101)
  endtask : t_standby

  task automatic t_frames();
    i_host.wr(ADDR_PROF_A, 8'h00);
    i_host.wr(ADDR_PROF_B, 8'h09);
    i_host.wr(ADDR_PROF_SEL, 8'h22);
    i_host.wr(ADDR_STANDBY, 8'h01);
    i_host.rd(ADDR_PROF_SEL, d);
    `CHK(d, 8'h2a)
    `CHK({cfg[1].prof_b, cfg[1].sinc5, cfg[1].dec_code, cfg[2].sinc5}, 6'b110010)
    ticks(31);
    `CHK(n_frames, 0)
    ticks(1);
    `CHK(n_frames, 1)
    `CHK(cap[0], 32'h0000_0000)
    `CHK(cap[2], raw[2])
    `CHK({cap[1], cap[3]}, 64'h4500_0000_4500_0000)
    ticks(32);
    `CHK(n_frames, 2)
    `CHK(cap[3], raw[3])
  endtask : t_frames

  task automatic t_sleep();
    i_host.wr(ADDR_POWER, 8'h80);
    i_host.rd(ADDR_POWER, d);
    `CHK({adc, d}, 9'h080)
    ticks(64);
    `CHK(n_frames, 2)
    i_host.wr(ADDR_POWER, 8'h00);
    `CHK(adc, 1'b1)
  endtask : t_sleep

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_frames();
    t_standby();
    t_sleep();
    finish_test();
  end
endmodule : tb
